// file: core/byte_reg.sv
`timescale 1ns/1ns
module byte_reg #(
    parameter int unsigned W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic    clk,
    input wire logic    nrst,
    byte_reg_if.store   rg
);

    logic [W-1:0] q_r;    // stored value
    logic [W-1:0] q_nxt;  // next stored value

    // software write wins over a hardware load in the same cycle
    always_comb begin
        q_nxt = q_r;
        if (rg.wr_en) begin
            q_nxt = rg.wr_data;
        end else if (rg.hw_load) begin
            q_nxt = rg.hw_data;
        end
    end

    // register, constant on reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign rg.q = q_r;

    a_reg_reset_val: assert property (@(posedge clk) $rose(nrst) |-> q_r == RST)
        else $error("register not at reset value after reset");
    a_reg_sw_write: assert property (@(posedge clk) disable iff (!nrst)
        rg.wr_en |=> q_r == $past(rg.wr_data))
        else $error("software write not stored");
    a_reg_hold: assert property (@(posedge clk) disable iff (!nrst)
        !rg.wr_en && !rg.hw_load |=> $stable(q_r))
        else $error("register changed without a write or load");

endmodule

// file: core/pin_route.sv
`timescale 1ns/1ns
module pin_route (
    input wire logic enable,
    input wire logic wave16,
    input wire logic wave8,
    input wire logic dual,
    input wire logic invert,
    input wire logic latch_bit,
    output logic     pin_level
);

    // pick the waveform for the mode, else the port latch data
    always_comb begin
        if (enable) begin
            pin_level = (dual ? wave8 : wave16) ^ invert;
        end else begin
            pin_level = latch_bit;
        end
    end

endmodule

// file: core/timer_output_top.sv
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ns
// Contract
// - 16-bit mode: enable bits route PWM per pin
// - dual mode, primary bit: high-byte 8-bit PWM
// - dual mode, alternate bit: low-byte 8-bit PWM
// - both enables clear: both pins show latch
// - interrupt enable gates overflow and capture flags
// - count high byte read/write, upper count, reset 00h
// - reload high byte read/write, reset 00h
// - capture/compare high byte read/write, reset 00h
// - port output latch resets to 1Fh
// - latch bit drives output or pull-up
// - latch write stores, read returns latch
// - direction change leaves latch unchanged
// - latch bit 7 reads zero
// - polarity applies only when primary enable rises
module timer_output_top #(
    parameter int unsigned PRIMARY_BIT = 0,  // port bit shared with primary pin
    parameter int unsigned ALT_BIT     = 1   // port bit shared with alternate pin
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    output logic [31:0]     avs_readdata,
    output logic            avs_waitrequest,
    input wire logic        pwm16_wave,
    input wire logic        pwm8_hi_wave,
    input wire logic        pwm8_lo_wave,
    input wire logic        count_hi_load,
    input wire logic [7:0]  count_hi_in,
    output logic [7:0]      count_high_byte,
    output logic [7:0]      reload_high_byte,
    input wire logic        cc_hi_load,
    input wire logic [7:0]  cc_hi_in,
    output logic [7:0]      capture_compare_high_byte,
    output logic            dual_byte_mode,
    input wire logic        overflow_flag,
    input wire logic        capture_compare_flag,
    output logic            timer_irq,
    input wire logic [6:0]  port_dir,
    output logic [6:0]      port_pad_out,
    output logic [6:0]      port_pad_oe,
    output logic [6:0]      port_pullup_en
);

    localparam int unsigned LW = timer_out_pkg::LATCH_W;

    // bus slave state
    timer_out_pkg::bus_state_e state_r;     // current slave state
    timer_out_pkg::bus_state_e state_nxt;   // next slave state
    logic [31:0]               rdata_r;     // registered read data
    logic [31:0]               rdata_nxt;   // next read data
    logic                      wr_go;       // write takes effect this edge
    logic [7:0]                wbyte;       // low write byte

    // control state
    logic [timer_out_pkg::CTRL_W-1:0] ctrl_r;       // enables, mode, polarity, irq enable
    logic [timer_out_pkg::CTRL_W-1:0] ctrl_nxt;
    logic                             oe_pri_d_r;   // primary enable one cycle ago
    logic                             oe_pri_d_nxt;
    logic                             start_lvl_r;  // starting level applied to primary pin
    logic                             start_lvl_nxt;
    logic                             irq_r;        // gated interrupt request
    logic                             irq_nxt;

    // pin state
    logic [6:0] pad_out_r;
    logic [6:0] pad_out_nxt;
    logic [6:0] pad_oe_r;
    logic [6:0] pad_oe_nxt;
    logic [6:0] pullup_r;
    logic [6:0] pullup_nxt;
    logic       pri_level;  // routed primary pin level
    logic       alt_level;  // routed alternate pin level

    // shorthand control fields
    logic oe_pri;
    logic oe_alt;
    logic dual;
    logic pol;
    logic irq_en;
    assign oe_pri = ctrl_r[timer_out_pkg::CTRL_OE_PRI];
    assign oe_alt = ctrl_r[timer_out_pkg::CTRL_OE_ALT];
    assign dual   = ctrl_r[timer_out_pkg::CTRL_DUAL];
    assign pol    = ctrl_r[timer_out_pkg::CTRL_POL];
    assign irq_en = ctrl_r[timer_out_pkg::CTRL_IE];

    // storage registers
    byte_reg_if #(.W(8))  cnt_if ();
    byte_reg_if #(.W(8))  rld_if ();
    byte_reg_if #(.W(8))  cc_if ();
    byte_reg_if #(.W(LW)) lat_if ();

    assign wr_go = (state_r == timer_out_pkg::BUS_ACK) && avs_write && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    // software and hardware access to the byte registers
    assign cnt_if.wr_en   = wr_go && (avs_address == timer_out_pkg::ADDR_COUNT_HI);
    assign cnt_if.wr_data = wbyte;
    assign cnt_if.hw_load = count_hi_load;  // counter carries its upper byte here
    assign cnt_if.hw_data = count_hi_in;
    assign rld_if.wr_en   = wr_go && (avs_address == timer_out_pkg::ADDR_RELOAD_HI);
    assign rld_if.wr_data = wbyte;
    assign rld_if.hw_load = 1'b0;  // reload value only changes from software
    assign rld_if.hw_data = 8'h00;
    assign cc_if.wr_en    = wr_go && (avs_address == timer_out_pkg::ADDR_CC_HI);
    assign cc_if.wr_data  = wbyte;
    assign cc_if.hw_load  = cc_hi_load;  // capture events land here
    assign cc_if.hw_data  = cc_hi_in;
    // only a bus write changes the latch; port_dir never reaches it
    assign lat_if.wr_en   = wr_go && (avs_address == timer_out_pkg::ADDR_LATCH);
    assign lat_if.wr_data = wbyte[LW-1:0];
    assign lat_if.hw_load = 1'b0;
    assign lat_if.hw_data = '0;

    byte_reg #(.W(8), .RST(timer_out_pkg::RST_COUNT_HI)) u_count_hi (
        .clk  (clk),
        .nrst (nrst),
        .rg   (cnt_if.store)
    );
    byte_reg #(.W(8), .RST(timer_out_pkg::RST_RELOAD_HI)) u_reload_hi (
        .clk  (clk),
        .nrst (nrst),
        .rg   (rld_if.store)
    );
    byte_reg #(.W(8), .RST(timer_out_pkg::RST_CC_HI)) u_cc_hi (
        .clk  (clk),
        .nrst (nrst),
        .rg   (cc_if.store)
    );
    byte_reg #(.W(LW), .RST(timer_out_pkg::RST_LATCH)) u_latch (
        .clk  (clk),
        .nrst (nrst),
        .rg   (lat_if.store)
    );

    // bus slave: take request, answer one cycle later
    always_comb begin
        state_nxt = state_r;
        rdata_nxt = rdata_r;
        case (state_r)
            timer_out_pkg::BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    state_nxt = timer_out_pkg::BUS_ACK;
                end
                // unmapped or write reads zero
                rdata_nxt = 32'h0000_0000;
                if (avs_read) begin
                    case (avs_address)
                        timer_out_pkg::ADDR_COUNT_HI:  rdata_nxt[7:0] = cnt_if.q;
                        timer_out_pkg::ADDR_RELOAD_HI: rdata_nxt[7:0] = rld_if.q;
                        timer_out_pkg::ADDR_CC_HI:     rdata_nxt[7:0] = cc_if.q;
                        // stored latch, not pins; bit 7 stays zero
                        timer_out_pkg::ADDR_LATCH:     rdata_nxt[LW-1:0] = lat_if.q;
                        timer_out_pkg::ADDR_CTRL:      rdata_nxt[timer_out_pkg::CTRL_W-1:0] = ctrl_r;
                        timer_out_pkg::ADDR_STATUS: begin
                            rdata_nxt[timer_out_pkg::STAT_OVF]   = overflow_flag;
                            rdata_nxt[timer_out_pkg::STAT_CCF]   = capture_compare_flag;
                            rdata_nxt[timer_out_pkg::STAT_IRQ]   = irq_r;
                            rdata_nxt[timer_out_pkg::STAT_START] = start_lvl_r;
                        end
                        default: rdata_nxt = 32'h0000_0000;
                    endcase
                end
            end
            timer_out_pkg::BUS_ACK: begin
                // answered; master drops its request at this edge
                state_nxt = timer_out_pkg::BUS_IDLE;
            end
            default: begin
                state_nxt = timer_out_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= timer_out_pkg::BUS_IDLE;
            rdata_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest = (state_r != timer_out_pkg::BUS_ACK);
    assign avs_readdata    = rdata_r;

    // control register, start level capture and interrupt gate
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_go && (avs_address == timer_out_pkg::ADDR_CTRL)) begin
            ctrl_nxt = wbyte[timer_out_pkg::CTRL_W-1:0];
        end
        oe_pri_d_nxt  = oe_pri;
        // polarity only reaches the pin on a 0 to 1 enable edge
        start_lvl_nxt = (oe_pri && !oe_pri_d_r) ? pol : start_lvl_r;
        // one enable gates both flag sources
        irq_nxt = irq_en && (overflow_flag || capture_compare_flag);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r      <= timer_out_pkg::RST_CTRL;
            oe_pri_d_r  <= 1'b0;
            start_lvl_r <= 1'b0;
            irq_r       <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            oe_pri_d_r  <= oe_pri_d_nxt;
            start_lvl_r <= start_lvl_nxt;
            irq_r       <= irq_nxt;
        end
    end

    // pin routing; only the primary pin takes the start level
    pin_route u_pri (
        .enable    (oe_pri),
        .wave16    (pwm16_wave),
        .wave8     (pwm8_hi_wave),
        .dual      (dual),
        .invert    (start_lvl_r),
        .latch_bit (lat_if.q[PRIMARY_BIT]),
        .pin_level (pri_level)
    );
    pin_route u_alt (
        .enable    (oe_alt),
        .wave16    (pwm16_wave),
        .wave8     (pwm8_lo_wave),
        .dual      (dual),
        .invert    (1'b0),
        .latch_bit (lat_if.q[ALT_BIT]),
        .pin_level (alt_level)
    );

    // pad drive: latch bit is output level or pull-up switch
    always_comb begin
        pad_out_nxt = lat_if.q;
        pad_oe_nxt  = port_dir;
        pullup_nxt  = ~port_dir & lat_if.q;
        pad_out_nxt[PRIMARY_BIT] = pri_level;
        pad_out_nxt[ALT_BIT]     = alt_level;
        // timer drive forces the pad out, no pull-up needed then
        if (oe_pri) begin
            pad_oe_nxt[PRIMARY_BIT] = 1'b1;
            pullup_nxt[PRIMARY_BIT] = 1'b0;
        end
        if (oe_alt) begin
            pad_oe_nxt[ALT_BIT] = 1'b1;
            pullup_nxt[ALT_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pad_out_r <= 7'h00;
            pad_oe_r  <= 7'h00;
            pullup_r  <= 7'h00;
        end else begin
            pad_out_r <= pad_out_nxt;
            pad_oe_r  <= pad_oe_nxt;
            pullup_r  <= pullup_nxt;
        end
    end

    assign port_pad_out              = pad_out_r;
    assign port_pad_oe               = pad_oe_r;
    assign port_pullup_en            = pullup_r;
    assign timer_irq                 = irq_r;
    assign count_high_byte           = cnt_if.q;
    assign reload_high_byte          = rld_if.q;
    assign capture_compare_high_byte = cc_if.q;
    assign dual_byte_mode            = dual;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_pri_route16: assert property (oe_pri && !dual
        |=> pad_out_r[PRIMARY_BIT] == ($past(pwm16_wave) ^ $past(start_lvl_r)))
        else $error("primary pin not carrying 16-bit waveform");
    a_alt_route16: assert property (oe_alt && !dual |=> pad_out_r[ALT_BIT] == $past(pwm16_wave))
        else $error("alternate pin not carrying 16-bit waveform");
    a_pri_route8: assert property (oe_pri && dual
        |=> pad_out_r[PRIMARY_BIT] == ($past(pwm8_hi_wave) ^ $past(start_lvl_r)))
        else $error("primary pin not carrying high-byte waveform");
    a_alt_route8: assert property (oe_alt && dual |=> pad_out_r[ALT_BIT] == $past(pwm8_lo_wave))
        else $error("alternate pin not carrying low-byte waveform");
    a_latch_route: assert property (!oe_pri && !oe_alt ##1 1 |-> pad_out_r == $past(lat_if.q))
        else $error("pins not showing latch data with timer outputs off");
    a_irq_gate: assert property (!irq_en |=> !timer_irq)
        else $error("interrupt raised while locally disabled");
    a_irq_source: assert property (irq_en && (overflow_flag || capture_compare_flag) |=> timer_irq)
        else $error("enabled flag did not raise interrupt");
    a_latch_readback: assert property (avs_read && avs_waitrequest && avs_address == timer_out_pkg::ADDR_LATCH
        |=> !avs_waitrequest && avs_readdata[7:0] == {1'b0, lat_if.q})
        else $error("latch read did not return stored value with bit 7 zero");
    a_pol_hold: assert property (!(oe_pri && !oe_pri_d_r) |=> $stable(start_lvl_r))
        else $error("start level changed without an enable rise");
    a_pullup_ctl: assert property (!oe_pri && !oe_alt
        |=> pullup_r == ($past(~port_dir) & $past(lat_if.q)))
        else $error("pull-up not following latch on input pins");

    c_latch_write: cover property (lat_if.wr_en);
    c_pri_enable_rise: cover property (oe_pri && !oe_pri_d_r && pol);
    c_dual_both: cover property (dual && oe_pri && oe_alt);
    c_irq_fire: cover property ($rose(timer_irq));

endmodule

// file: include/byte_reg_if.sv
`timescale 1ns/1ns
// one storage register: software write port, hardware load port, value out
interface byte_reg_if #(parameter int unsigned W = 8);
    logic         wr_en;    // software write strobe
    logic [W-1:0] wr_data;  // software write value
    logic         hw_load;  // hardware load strobe
    logic [W-1:0] hw_data;  // hardware load value
    logic [W-1:0] q;        // stored value

    modport store (input wr_en, input wr_data, input hw_load, input hw_data, output q);
    modport user  (output wr_en, output wr_data, output hw_load, output hw_data, input q);
endinterface

// file: include/timer_out_pkg.sv
package timer_out_pkg;

    // bus geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_COUNT_HI  = 8'h01;
    localparam logic [7:0] IDX_RELOAD_HI = 8'h02;
    localparam logic [7:0] IDX_CC_HI     = 8'h03;
    localparam logic [7:0] IDX_LATCH     = 8'h04;
    localparam logic [7:0] IDX_CTRL      = 8'h08;
    localparam logic [7:0] IDX_STATUS    = 8'h09;

    localparam logic [7:0] ADDR_COUNT_HI  = {IDX_COUNT_HI[5:0], 2'b00};
    localparam logic [7:0] ADDR_RELOAD_HI = {IDX_RELOAD_HI[5:0], 2'b00};
    localparam logic [7:0] ADDR_CC_HI     = {IDX_CC_HI[5:0], 2'b00};
    localparam logic [7:0] ADDR_LATCH     = {IDX_LATCH[5:0], 2'b00};
    localparam logic [7:0] ADDR_CTRL      = {IDX_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_STATUS    = {IDX_STATUS[5:0], 2'b00};

    // reset values
    localparam logic [7:0] RST_COUNT_HI  = 8'h00;
    localparam logic [7:0] RST_RELOAD_HI = 8'h00;
    localparam logic [7:0] RST_CC_HI     = 8'h00;
    localparam logic [6:0] RST_LATCH     = 7'h1f;
    localparam logic [4:0] RST_CTRL      = 5'h00;

    // port latch geometry
    localparam int unsigned LATCH_W = 7;

    // control register fields
    localparam int unsigned CTRL_OE_PRI  = 0;
    localparam int unsigned CTRL_OE_ALT  = 1;
    localparam int unsigned CTRL_DUAL    = 2;
    localparam int unsigned CTRL_POL     = 3;
    localparam int unsigned CTRL_IE      = 4;
    localparam int unsigned CTRL_W       = 5;

    // status register fields
    localparam int unsigned STAT_OVF     = 0;
    localparam int unsigned STAT_CCF     = 1;
    localparam int unsigned STAT_IRQ     = 2;
    localparam int unsigned STAT_START   = 3;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_e;

endpackage

// file: verif/pin_partner.sv
`timescale 1ns/1ns
// stand-in for the counter logic: three free-running waveforms
module pin_partner (
    input wire logic clk,
    input wire logic nrst,
    output logic     pwm16_wave,
    output logic     pwm8_hi_wave,
    output logic     pwm8_lo_wave
);
    logic [3:0] cnt_r;    // free-running count
    logic [3:0] cnt_nxt;  // next count

    // next count; one adder is enough, the waves only need to differ
    always_comb begin
        cnt_nxt = cnt_r + 4'h1;
    end

    // register; all waves start low out of reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // distinct rates so a wrong route cannot match by chance
    assign pwm16_wave   = cnt_r[0];
    assign pwm8_hi_wave = cnt_r[1];
    assign pwm8_lo_wave = cnt_r[2];
endmodule

// file: verif/timer_output_and_byte_regs_tb.sv
`timescale 1ns/1ns
module timer_output_and_byte_regs_tb;
    // table row: enables, mode, pin sources (0 latch, 1 wide, 2 high, 3 low)
    typedef struct packed {
        logic [1:0] oe;
        logic       dual;
        logic [1:0] s0;
        logic [1:0] s1;
    } row_s;

    logic        clk           = 1'b0;   // 100 MHz
    logic        nrst          = 1'b0;   // held low at start
    logic [7:0]  avs_address   = 8'h00;  // bus address
    logic        avs_read      = 1'b0;   // read request
    logic        avs_write     = 1'b0;   // write request
    logic [31:0] avs_writedata = 32'h0;  // write data
    logic [31:0] avs_readdata;           // read data
    logic        avs_waitrequest;        // slave stall
    logic        w16;                    // partner waves
    logic        w8h;
    logic        w8l;
    logic        count_hi_load = 1'b0;   // hardware loads
    logic [7:0]  count_hi_in   = 8'h00;
    logic        cc_hi_load    = 1'b0;
    logic [7:0]  cc_hi_in      = 8'h00;
    logic [7:0]  count_high_byte;        // register outputs
    logic [7:0]  reload_high_byte;
    logic [7:0]  capture_compare_high_byte;
    logic        dual_byte_mode;
    logic        overflow_flag = 1'b0;   // flag inputs
    logic        capture_compare_flag = 1'b0;
    logic        timer_irq;
    logic [6:0]  port_dir = 7'h7f;       // all outputs
    logic [6:0]  port_pad_out;
    logic [6:0]  port_pad_oe;
    logic [6:0]  port_pullup_en;
    logic [2:0]  pw;                     // waves seen one cycle earlier
    logic [31:0] q;                      // last read data
    logic [7:0]  regs [3] = '{timer_out_pkg::ADDR_COUNT_HI, timer_out_pkg::ADDR_RELOAD_HI, timer_out_pkg::ADDR_CC_HI};
    int          n_fail = 0;
    int          checks_done = 0;
    row_s        rows [8] = '{'{2'b00, 1'b0, 2'd0, 2'd0}, '{2'b01, 1'b0, 2'd1, 2'd0},
                              '{2'b10, 1'b0, 2'd0, 2'd1}, '{2'b11, 1'b0, 2'd1, 2'd1},
                              '{2'b00, 1'b1, 2'd0, 2'd0}, '{2'b01, 1'b1, 2'd2, 2'd0},
                              '{2'b10, 1'b1, 2'd0, 2'd3}, '{2'b11, 1'b1, 2'd2, 2'd3}};

    // clock
    always #5 clk = ~clk;

    pin_partner pin_partner_inst (.clk(clk), .nrst(nrst), .pwm16_wave(w16), .pwm8_hi_wave(w8h), .pwm8_lo_wave(w8l));

    timer_output_top timer_output_top_inst (
        .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pwm16_wave(w16), .pwm8_hi_wave(w8h), .pwm8_lo_wave(w8l),
        .count_hi_load(count_hi_load), .count_hi_in(count_hi_in), .count_high_byte(count_high_byte),
        .reload_high_byte(reload_high_byte), .cc_hi_load(cc_hi_load), .cc_hi_in(cc_hi_in),
        .capture_compare_high_byte(capture_compare_high_byte), .dual_byte_mode(dual_byte_mode),
        .overflow_flag(overflow_flag), .capture_compare_flag(capture_compare_flag), .timer_irq(timer_irq),
        .port_dir(port_dir), .port_pad_out(port_pad_out), .port_pad_oe(port_pad_oe),
        .port_pullup_en(port_pullup_en));

    // value compare, case equality so unknowns fail
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus cycle; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            n_fail++;
            $display("ERROR %0t: no bus answer", $time);
        end
    endtask

    // read and compare one byte register; upper bits must be zero
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, {24'h0, exp});
    endtask

    // source of one pin from the waves of the previous cycle
    function automatic logic pick(input logic [1:0] s, input logic inv, input logic lb);
        case (s)
            2'd0: return lb;
            2'd1: return pw[0] ^ inv;
            2'd2: return pw[1] ^ inv;
            default: return pw[2];
        endcase
    endfunction

    // let the route settle, then follow the pads for eight cycles; latch holds 01h
    task automatic pads(input logic [1:0] s0, input logic [1:0] s1, input logic inv);
        repeat (4) begin
            @(negedge clk);
            pw = {w8l, w8h, w16};
        end
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            chk(32'(port_pad_out[1:0]), 32'({pick(s1, 1'b0, 1'b0), pick(s0, inv, 1'b1)}));
            pw = {w8l, w8h, w16};
        end
    endtask

    // reset values of every register except status, plus an unmapped place
    task automatic reset_regs;
        rd(timer_out_pkg::ADDR_COUNT_HI, 8'h00);
        rd(timer_out_pkg::ADDR_RELOAD_HI, 8'h00);
        rd(timer_out_pkg::ADDR_CC_HI, 8'h00);
        rd(timer_out_pkg::ADDR_LATCH, 8'h1f);
        rd(8'h40, 8'h00);
        rd(timer_out_pkg::ADDR_CTRL, 8'h00);
    endtask

    // verdict, the only way out
    task automatic give_verdict;
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog; the whole run takes well under 2000 cycles
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        reset_regs();
        bus(1'b1, timer_out_pkg::ADDR_LATCH, 32'h01);
        // routing table
        foreach (rows[i]) begin
            bus(1'b1, timer_out_pkg::ADDR_CTRL, 32'(rows[i].oe) | (32'(rows[i].dual) << timer_out_pkg::CTRL_DUAL));
            pads(rows[i].s0, rows[i].s1, 1'b0);
            chk(32'(dual_byte_mode), 32'(rows[i].dual));
        end
        // polarity only lands on a rising primary enable
        bus(1'b1, timer_out_pkg::ADDR_CTRL, 32'h01);
        pads(2'd1, 2'd0, 1'b0);
        bus(1'b1, timer_out_pkg::ADDR_CTRL, 32'h09);
        pads(2'd1, 2'd0, 1'b0);
        rd(timer_out_pkg::ADDR_CTRL, 8'h09);
        bus(1'b1, timer_out_pkg::ADDR_CTRL, 32'h00);
        bus(1'b1, timer_out_pkg::ADDR_CTRL, 32'h09);
        pads(2'd1, 2'd0, 1'b1);
        bus(1'b1, timer_out_pkg::ADDR_CTRL, 32'h00);
        // byte registers, software side
        foreach (regs[k]) begin
            bus(1'b1, regs[k], 32'ha0 + 32'(k));
            rd(regs[k], 8'ha0 + 8'(k));
        end
        chk({8'h0, count_high_byte, reload_high_byte, capture_compare_high_byte}, 32'h00a0a1a2);
        // hardware loads of the upper count and capture bytes
        @(posedge clk);
        count_hi_load <= 1'b1;
        count_hi_in   <= 8'h3c;
        cc_hi_load    <= 1'b1;
        cc_hi_in      <= 8'hc3;
        @(posedge clk);
        count_hi_load <= 1'b0;
        cc_hi_load    <= 1'b0;
        rd(timer_out_pkg::ADDR_COUNT_HI, 8'h3c);
        rd(timer_out_pkg::ADDR_CC_HI, 8'hc3);
        // latch: stored value, reserved bit, pads and pull-ups
        bus(1'b1, timer_out_pkg::ADDR_LATCH, 32'hff);
        rd(timer_out_pkg::ADDR_LATCH, 8'h7f);
        repeat (3) @(negedge clk);
        chk(32'(port_pad_out), 32'h7f);
        @(posedge clk);
        port_dir <= 7'h00;
        rd(timer_out_pkg::ADDR_LATCH, 8'h7f);
        bus(1'b1, timer_out_pkg::ADDR_LATCH, 32'h2b);
        repeat (3) @(negedge clk);
        chk(32'(port_pullup_en), 32'h2b);
        bus(1'b1, timer_out_pkg::ADDR_CTRL, 32'h03);
        repeat (4) @(negedge clk);
        chk({port_pullup_en, port_pad_oe}, {7'h28, 7'h03});
        // interrupt gate over every flag pair, disabled then enabled
        for (int ie = 0; ie < 2; ie++) begin
            bus(1'b1, timer_out_pkg::ADDR_CTRL, 32'(ie) << timer_out_pkg::CTRL_IE);
            for (int f = 0; f < 4; f++) begin
                @(posedge clk);
                {capture_compare_flag, overflow_flag} <= 2'(f);
                repeat (3) @(negedge clk);
                chk(32'(timer_irq), 32'(ie != 0 && f != 0));
                rd(timer_out_pkg::ADDR_STATUS, {5'h00, ie != 0 && f != 0, 2'(f)});
            end
        end
        // second reset in mid-run
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        reset_regs();
        @(negedge clk);
        chk({timer_irq, port_pullup_en, port_pad_oe}, {1'b0, 7'h1f, 7'h00});
        give_verdict();
    end
endmodule
